// >>> design/mirror_branch_cfg.svh
// Constants for the mirrored memory branch controller.
`ifndef MIRROR_BRANCH_CFG_SVH
`define MIRROR_BRANCH_CFG_SVH
`define ADDR_W 36
`define MIRROR_LIMIT_BIT 35
`define BRANCH_SEL_BIT 6
`define FRAME_XFERS 12
`define NB_LANES 14
`define NB_IDLE_LANE 13
`define SB_LANES 10
`define SB_CH_BYTES 8
`define NB_CH_BYTES 16
`define BAD_DEV_THRESH 4'h3
`define DEV_COUNT 18
`define SINGLE_BEATS 4
`define SINGLE_BEAT_BYTES 8
`endif

// >>> design/mirror_branch_pkg.sv
// Types shared by the mirrored memory branch controller.
package mirror_branch_pkg;
	typedef enum logic [1:0] {MODE_UNSET, MODE_DUAL, MODE_SINGLE, MODE_MIRROR} mode_t;
	typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD, ST_RETRY} state_t;
endpackage : mirror_branch_pkg

// >>> design/frame_slicer.sv
// Northbound frame deserializer clocked by sampled edges of the reference clock.
`timescale 1ns/10ps
`include "mirror_branch_cfg.svh"
module frame_slicer #(
	parameter int LANES = 26,
	parameter int XFERS = `FRAME_XFERS,
	parameter int PAY_W = 256
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_link_clk,
	input wire logic [LANES-1:0] i_lanes,
	output logic o_xfer,
	output logic o_frame_end,
	output logic [PAY_W-1:0] o_payload,
	output logic o_valid
);
	localparam int SH_W = LANES * XFERS;

	logic clk_s1_q;
	logic clk_s2_q;
	logic clk_s3_q;
	logic [LANES-1:0] lane_s1_q;
	logic [LANES-1:0] lane_s2_q;
	logic [3:0] cnt_q;
	logic [SH_W-1:0] shift_q;
	wire rise;
	wire last;
	wire [SH_W-1:0] shift_d;

	// The reference clock is slow against i_clk, so edges are found by sampling.
	assign rise = clk_s2_q & ~clk_s3_q;
	assign last = rise && (cnt_q == 4'(XFERS - 1));
	assign shift_d = {shift_q[SH_W-LANES-1:0], lane_s2_q};

	// Clock and lanes pass the same two stages, so data stays aligned to the edge.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			lane_s1_q <= '0;
			lane_s2_q <= '0;
		end else begin
			clk_s1_q <= i_link_clk;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			lane_s1_q <= i_lanes;
			lane_s2_q <= lane_s1_q;
		end
	end

	// One transfer per rising reference edge; the first transfers carry the payload.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= 4'h0;
			shift_q <= '0;
			o_payload <= '0;
			o_valid <= 1'b0;
			o_xfer <= 1'b0;
			o_frame_end <= 1'b0;
		end else begin
			o_xfer <= rise;
			o_frame_end <= last;
			o_valid <= last;
			if (rise) begin
				shift_q <= shift_d;
				cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
			end
			if (last) begin
				o_payload <= shift_d[SH_W-1 -: PAY_W];
			end
		end
	end
endmodule : frame_slicer

// >>> design/mirrored_memory_branch_control.sv
// Branch operating modes, mirroring, read retry and channel framing.
`timescale 1ns/10ps
`include "mirror_branch_cfg.svh"
module mirrored_memory_branch_control #(
	parameter int AW = `ADDR_W,
	parameter int DEVS = `DEV_COUNT
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_link_clk,
	input wire logic i_cfg_load,
	input wire logic i_cfg_mirror,
	input wire logic i_cfg_single,
	input wire logic [2:0] i_speed_b0,
	input wire logic [2:0] i_speed_b1,
	input wire logic i_sw_degrade,
	input wire logic i_sw_degrade_br,
	input wire logic i_sw_resume,
	input wire logic [1:0] i_dimm_fail,
	input wire logic i_stat_clr,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [AW-1:0] i_req_addr,
	input wire logic [AW-1:0] i_req_addr_b,
	input wire logic [127:0] i_req_wdata,
	input wire logic [1:0] i_br_ack,
	input wire logic [1:0] i_ret_valid,
	input wire logic [255:0] i_ret_data0,
	input wire logic [255:0] i_ret_data1,
	input wire logic [1:0] i_ret_ce,
	input wire logic [1:0] i_ret_ue,
	input wire logic [1:0] i_ret_single_bit,
	input wire logic [4:0] i_ret_dev0,
	input wire logic [4:0] i_ret_dev1,
	input wire logic i_ret_adj16,
	input wire logic [27:0] i_nb_lanes0,
	input wire logic [27:0] i_nb_lanes1,
	output mirror_branch_pkg::mode_t o_mode,
	output logic o_ecc_single,
	output logic [2:0] o_run_speed,
	output logic [1:0] o_online,
	output logic o_req_ready,
	output logic o_req_refused,
	output logic [1:0] o_br_cmd_valid,
	output logic o_br_cmd_write,
	output logic [AW-1:0] o_br_addr0,
	output logic [AW-1:0] o_br_addr1,
	output logic o_wr_done,
	output logic o_resp_valid,
	output logic [255:0] o_resp_data,
	output logic o_resp_branch,
	output logic o_resp_err,
	output logic o_flag_offline,
	output logic o_flag_ue_retry,
	output logic [19:0] o_sb_lanes0,
	output logic [19:0] o_sb_lanes1,
	output logic [255:0] o_nb_payload0,
	output logic [255:0] o_nb_payload1,
	output logic [1:0] o_nb_valid
);
	localparam int SB_W = 2 * `SB_LANES * `FRAME_XFERS;
	localparam int SB_PAY = 2 * `SB_CH_BYTES * 8;
	localparam int NB_PAY = 2 * `NB_CH_BYTES * 8;
	localparam int BEAT_W = `SINGLE_BEAT_BYTES * 8;
	localparam int CW_W = BEAT_W * (`SINGLE_BEATS - 1);

	mirror_branch_pkg::mode_t mode_q;
	mirror_branch_pkg::state_t st_q;
	mirror_branch_pkg::state_t st_d;
	logic cfg_done_q;
	logic [1:0] online_q;
	logic [1:0] failed_q;
	logic [1:0] need_q;
	logic [1:0] got_q;
	logic [1:0] ack_q;
	logic retried_q;
	logic retry_pend_q;
	logic retry_br_q;
	logic [AW-1:0] retry_addr_q;
	logic [AW-1:0] addr0_q;
	logic [AW-1:0] addr1_q;
	logic [1:0] beat_q;
	logic [CW_W-1:0] cw_q;
	logic [3:0] bad_cnt_q [DEVS];
	logic [1:0] pend_v_q;
	logic pend_w_q;
	logic [AW-1:0] pend_addr_q [2];
	logic [SB_PAY-1:0] pend_data_q;
	logic [SB_W-1:0] sb_sh_q [2];
	logic xfer;
	logic frame_end;
	logic [DEVS-1:0] mark_v;

	// Mode and branch availability decode.
	wire mirror = (mode_q == mirror_branch_pkg::MODE_MIRROR);
	wire single = (mode_q == mirror_branch_pkg::MODE_SINGLE);
	wire both_on = &online_q;
	wire cfg_take = i_cfg_load && !cfg_done_q;
	wire req_take = (st_q == mirror_branch_pkg::ST_IDLE) && i_req_valid && cfg_done_q;
	// Mirrored range limit
	// Mirrored space limit.
	wire range_err = mirror && i_req_addr[`MIRROR_LIMIT_BIT];
	wire issue = req_take && !range_err;
	wire retry_issue = (st_q == mirror_branch_pkg::ST_RETRY);
	// Target branch selection
	// Independent branch select.
	wire [1:0] tgt = mirror ? (both_on ? 2'b11 : online_q) :
		single ? 2'b01 : (i_req_addr[`BRANCH_SEL_BIT] ? 2'b10 : 2'b01);
	wire [1:0] retry_bit = retry_br_q ? 2'b10 : 2'b01;
	wire [1:0] cmd_v_d = issue ? tgt : (retry_issue ? retry_bit : 2'b00);
	wire [AW-1:0] cmd_a0_d = retry_issue ? retry_addr_q : i_req_addr;
	wire [AW-1:0] cmd_a1_d = retry_issue ? retry_addr_q :
		(mirror && both_on && !i_req_write) ? i_req_addr_b : i_req_addr;

	// Write completion needs every targeted acknowledge.
	// Wait all targeted acks.
	wire [1:0] ack_nx = ack_q | (i_br_ack & need_q);
	wire wr_all = (st_q == mirror_branch_pkg::ST_WR) && (ack_nx == need_q);

	// Return selection; branch 0 wins a tie since branch 1 is staggered.
	wire in_rd = (st_q == mirror_branch_pkg::ST_RD);
	wire rb = ~i_ret_valid[0];
	wire [1:0] rbit = rb ? 2'b10 : 2'b01;
	wire beat_last = (beat_q == 2'(`SINGLE_BEATS - 1));
	wire ret_fire = in_rd && (single ? (i_ret_valid[0] && beat_last) : (|i_ret_valid));
	wire r_ce = i_ret_ce[rb];
	wire r_ue = i_ret_ue[rb];
	wire r_sb = i_ret_single_bit[rb];
	wire [4:0] r_dev = rb ? i_ret_dev1 : i_ret_dev0;
	wire [255:0] r_data = single ? {i_ret_data0[BEAT_W-1:0], cw_q} : (rb ? i_ret_data1 : i_ret_data0);
	// Escalation of weak corrections
	// Marked device escalation.
	wire ue_eff = r_ue || (r_sb && (|mark_v)) || (single && r_ce && !i_ret_adj16);
	wire ret_retry = ret_fire && ue_eff && mirror && !retried_q && !retry_pend_q;
	wire retry_to = online_q[~rb] ? ~rb : rb;
	wire [1:0] got_nx = got_q | (ret_fire ? rbit : 2'b00);
	wire rd_all = ret_fire && (got_nx == need_q);
	wire dev_ok = (r_dev < 5'(DEVS));

	// Degrade, resume and failure shape the set of live branches.
	// Degrade keeps one branch.
	wire [1:0] deg_mask = i_sw_degrade_br ? 2'b10 : 2'b01;
	wire [1:0] on_deg = (i_sw_degrade && both_on) ? (online_q & ~deg_mask) : online_q;
	wire [1:0] on_res = i_sw_resume ? ~failed_q : on_deg;
	wire [1:0] failed_d = failed_q | i_dimm_fail;
	wire [1:0] online_d = (cfg_done_q && mirror) ? (on_res & ~failed_d) : online_q;
	wire off_evt = |(online_q & ~online_d);

	// Slowest speed within a mirrored slot position.
	// Slowest module speed.
	wire [2:0] speed_min = (i_speed_b1 < i_speed_b0) ? i_speed_b1 : i_speed_b0;
	wire mirror_branch_pkg::mode_t mode_d = i_cfg_mirror ? mirror_branch_pkg::MODE_MIRROR :
		i_cfg_single ? mirror_branch_pkg::MODE_SINGLE : mirror_branch_pkg::MODE_DUAL;

	genvar gd;
	generate
		for (gd = 0; gd < DEVS; gd++) begin : g_mark
			assign mark_v[gd] = (bad_cnt_q[gd] == `BAD_DEV_THRESH);
		end
	endgenerate

	// Transaction sequencing.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			mirror_branch_pkg::ST_IDLE: begin
				if (issue) begin
					st_d = i_req_write ? mirror_branch_pkg::ST_WR : mirror_branch_pkg::ST_RD;
				end
			end
			mirror_branch_pkg::ST_WR: begin
				if (wr_all) begin
					st_d = mirror_branch_pkg::ST_IDLE;
				end
			end
			mirror_branch_pkg::ST_RD: begin
				if (rd_all) begin
					st_d = (retry_pend_q || ret_retry) ? mirror_branch_pkg::ST_RETRY :
						mirror_branch_pkg::ST_IDLE;
				end
			end
			mirror_branch_pkg::ST_RETRY: begin
				st_d = mirror_branch_pkg::ST_RD;
			end
		endcase
	end

	// Configuration latch and branch state; the mode holds until reset.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_q <= mirror_branch_pkg::MODE_UNSET;
			cfg_done_q <= 1'b0;
			online_q <= 2'b00;
			failed_q <= 2'b00;
			o_run_speed <= 3'h0;
			o_ecc_single <= 1'b0;
		end else if (cfg_take) begin
			cfg_done_q <= 1'b1;
			mode_q <= mode_d;
			online_q <= (!i_cfg_mirror && i_cfg_single) ? 2'b01 : 2'b11;
			o_run_speed <= speed_min;
			o_ecc_single <= !i_cfg_mirror && i_cfg_single;
		end else if (mirror) begin
			online_q <= online_d;
			failed_q <= failed_d;
		end
	end

	// Request bookkeeping and branch commands.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= mirror_branch_pkg::ST_IDLE;
			need_q <= 2'b00;
			got_q <= 2'b00;
			ack_q <= 2'b00;
			retried_q <= 1'b0;
			addr0_q <= '0;
			addr1_q <= '0;
			o_br_cmd_valid <= 2'b00;
			o_br_cmd_write <= 1'b0;
			o_br_addr0 <= '0;
			o_br_addr1 <= '0;
			o_req_ready <= 1'b0;
			o_req_refused <= 1'b0;
			o_wr_done <= 1'b0;
		end else begin
			st_q <= st_d;
			o_br_cmd_valid <= cmd_v_d;
			o_br_cmd_write <= issue && i_req_write;
			o_br_addr0 <= cmd_a0_d;
			o_br_addr1 <= cmd_a1_d;
			o_req_ready <= (st_d == mirror_branch_pkg::ST_IDLE) && (cfg_done_q || cfg_take);
			o_req_refused <= req_take && range_err;
			o_wr_done <= wr_all;
			ack_q <= (issue || wr_all) ? 2'b00 : ack_nx;
			if (issue || retry_issue) begin
				need_q <= cmd_v_d;
				got_q <= 2'b00;
				retried_q <= retry_issue;
				addr0_q <= cmd_a0_d;
				addr1_q <= cmd_a1_d;
			end else if (ret_fire) begin
				got_q <= got_nx;
			end
		end
	end

	// Read answers, single-mode beat gathering and retry capture.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			beat_q <= 2'b00;
			cw_q <= '0;
			retry_pend_q <= 1'b0;
			retry_br_q <= 1'b0;
			retry_addr_q <= '0;
			o_resp_valid <= 1'b0;
			o_resp_data <= '0;
			o_resp_branch <= 1'b0;
			o_resp_err <= 1'b0;
		end else begin
			if (in_rd && single && i_ret_valid[0]) begin
				beat_q <= beat_q + 2'b01;
				cw_q <= {i_ret_data0[BEAT_W-1:0], cw_q[CW_W-1:BEAT_W]};
			end
			o_resp_valid <= (ret_fire && !ret_retry) || (req_take && range_err && !i_req_write);
			o_resp_data <= r_data;
			o_resp_branch <= rb;
			o_resp_err <= ret_fire ? ue_eff : range_err;
			if (ret_retry) begin
				retry_pend_q <= 1'b1;
				retry_br_q <= retry_to;
				retry_addr_q <= rb ? addr1_q : addr0_q;
			end else if (retry_issue) begin
				retry_pend_q <= 1'b0;
			end
		end
	end

	// Repeated correctable errors per device, saturating at the mark.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int d = 0; d < DEVS; d++) begin
				bad_cnt_q[d] <= 4'h0;
			end
		end else if (ret_fire && r_ce && !r_ue && dev_ok && !mark_v[r_dev]) begin
			bad_cnt_q[r_dev] <= bad_cnt_q[r_dev] + 4'h1;
		end
	end

	// Sticky status; a new event in the clearing cycle keeps the flag set.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_flag_offline <= 1'b0;
			o_flag_ue_retry <= 1'b0;
		end else begin
			o_flag_offline <= off_evt || (o_flag_offline && !i_stat_clr);
			o_flag_ue_retry <= ret_retry || (o_flag_ue_retry && !i_stat_clr);
		end
	end

	// Southbound frames carry the command header and write payload.
	// Commands and writes southbound.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_v_q <= 2'b00;
			pend_w_q <= 1'b0;
			pend_data_q <= '0;
			pend_addr_q[0] <= '0;
			pend_addr_q[1] <= '0;
			sb_sh_q[0] <= '0;
			sb_sh_q[1] <= '0;
			o_sb_lanes0 <= 20'h00000;
			o_sb_lanes1 <= 20'h00000;
		end else begin
			pend_v_q <= (pend_v_q & ~{2{frame_end}}) | cmd_v_d;
			if (issue) begin
				pend_w_q <= i_req_write;
				pend_data_q <= i_req_wdata;
			end
			if (cmd_v_d[0]) begin
				pend_addr_q[0] <= cmd_a0_d;
			end
			if (cmd_v_d[1]) begin
				pend_addr_q[1] <= cmd_a1_d;
			end
			if (xfer) begin
				o_sb_lanes0 <= sb_sh_q[0][SB_W-1 -: 20];
				o_sb_lanes1 <= sb_sh_q[1][SB_W-1 -: 20];
				for (int b = 0; b < 2; b++) begin
					sb_sh_q[b] <= frame_end ?
						{pend_v_q[b], pend_w_q, pend_addr_q[b], pend_data_q,
						(SB_W - SB_PAY - AW - 2)'(0)} : {sb_sh_q[b][SB_W-21:0], 20'h00000};
				end
			end
		end
	end

	// Northbound deserializers; lane 13 of each channel is left out of the frame.
	// Drop idle lane.
	frame_slicer #(.LANES(26), .XFERS(`FRAME_XFERS), .PAY_W(NB_PAY)) u_nb0 (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_link_clk(i_link_clk),
		.i_lanes({i_nb_lanes0[26:14], i_nb_lanes0[12:0]}),
		.o_xfer(xfer),
		.o_frame_end(frame_end),
		.o_payload(o_nb_payload0),
		.o_valid(o_nb_valid[0])
	);
	frame_slicer #(.LANES(26), .XFERS(`FRAME_XFERS), .PAY_W(NB_PAY)) u_nb1 (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_link_clk(i_link_clk),
		.i_lanes({i_nb_lanes1[26:14], i_nb_lanes1[12:0]}),
		.o_xfer(),
		.o_frame_end(),
		.o_payload(o_nb_payload1),
		.o_valid(o_nb_valid[1])
	);

	assign o_mode = mode_q;
	assign o_online = online_q;
endmodule : mirrored_memory_branch_control

// >>> test/mirrored_memory_branch_control_properties.sv
// Concurrent checks on the branch controller ports, bound into every instance.
`timescale 1ns/10ps
module mirrored_memory_branch_control_checker #(
	parameter int AW = 36
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_cfg_load,
	input wire logic i_cfg_mirror,
	input wire logic [2:0] i_speed_b0,
	input wire logic [2:0] i_speed_b1,
	input wire logic i_req_valid,
	input wire logic [AW-1:0] i_req_addr,
	input wire mirror_branch_pkg::mode_t o_mode,
	input wire logic o_ecc_single,
	input wire logic [2:0] o_run_speed,
	input wire logic [1:0] o_online,
	input wire logic o_req_ready,
	input wire logic o_req_refused,
	input wire logic [1:0] o_br_cmd_valid,
	input wire logic o_br_cmd_write,
	input wire logic o_wr_done,
	input wire logic o_flag_offline,
	input wire logic o_flag_ue_retry
);
	// One clock domain, so clocking and reset are declared once.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	chk_cfg_mirror_mode: assert property (
		i_cfg_load && o_mode == mirror_branch_pkg::MODE_UNSET && i_cfg_mirror
		|=> o_mode == mirror_branch_pkg::MODE_MIRROR && o_online == 2'h3)
		else $error("mirror mode not taken at configuration");
	chk_mode_held: assert property (
		o_mode != mirror_branch_pkg::MODE_UNSET |=> $stable(o_mode))
		else $error("operating mode changed after configuration");
	chk_speed_slowest: assert property (
		i_cfg_load && o_mode == mirror_branch_pkg::MODE_UNSET
		|=> o_run_speed == (($past(i_speed_b0) < $past(i_speed_b1)) ? $past(i_speed_b0)
		: $past(i_speed_b1)))
		else $error("run speed is not the slowest module");
	chk_ecc_code: assert property (
		o_mode != mirror_branch_pkg::MODE_UNSET
		|-> o_ecc_single == (o_mode == mirror_branch_pkg::MODE_SINGLE))
		else $error("wrong ECC code for mode");
	chk_single_branch: assert property (
		o_mode == mirror_branch_pkg::MODE_SINGLE |-> !o_br_cmd_valid[1])
		else $error("single mode used branch 1");
	chk_write_both: assert property (
		o_br_cmd_write && o_br_cmd_valid != 2'h0 && o_online == 2'h3
		&& o_mode == mirror_branch_pkg::MODE_MIRROR |-> o_br_cmd_valid == 2'h3)
		else $error("mirrored write not sent to both branches");
	chk_refuse_high: assert property (
		i_req_valid && o_req_ready && i_req_addr[35] && o_mode == mirror_branch_pkg::MODE_MIRROR
		|=> o_req_refused && o_br_cmd_valid == 2'h0)
		else $error("address above mirrored space not refused");
	chk_busy_cmd: assert property (o_br_cmd_valid != 2'h0 |-> !o_req_ready)
		else $error("ready while a command is out");
	chk_offline_flag: assert property (
		$fell(o_online[0]) || $fell(o_online[1]) |-> ##[0:1] o_flag_offline)
		else $error("branch taken offline without status flag");
	// Main scenarios that the bench is expected to reach.
	cov_mirror_write: cover property (o_wr_done && o_mode == mirror_branch_pkg::MODE_MIRROR);
	cov_ue_retry: cover property (o_flag_ue_retry);
	cov_degraded: cover property (o_online == 2'h1);
endmodule : mirrored_memory_branch_control_checker
bind mirrored_memory_branch_control mirrored_memory_branch_control_checker #(.AW(AW)) chk_i (
	.i_clk, .i_rst_b, .i_cfg_load, .i_cfg_mirror, .i_speed_b0, .i_speed_b1, .i_req_valid,
	.i_req_addr, .o_mode, .o_ecc_single, .o_run_speed, .o_online, .o_req_ready, .o_req_refused,
	.o_br_cmd_valid, .o_br_cmd_write, .o_wr_done, .o_flag_offline, .o_flag_ue_retry);

// >>> test/dimm_chain_model.sv
// Behavioural model of the module chains behind both branches.
`timescale 1ns/10ps
module dimm_chain_model (
	input wire logic i_clk,
	input wire logic [1:0] i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [35:0] i_addr0,
	input wire logic [35:0] i_addr1,
	input wire logic [1:0] i_bad,
	output logic [1:0] o_ack,
	output logic [1:0] o_ret_valid,
	output logic [1:0] o_ret_ue,
	output logic [255:0] o_data0,
	output logic [255:0] o_data1
);
	logic [5:0] rd0_q = 6'h00, rd1_q = 6'h00, wr0_q = 6'h00, wr1_q = 6'h00;
	logic [35:0] a0_q = 36'h0, a1_q = 36'h0;
	// Delay lines; one transaction per branch is outstanding at a time.
	always @(posedge i_clk) begin
		rd0_q <= {rd0_q[4:0], i_cmd_valid[0] & ~i_cmd_write};
		rd1_q <= {rd1_q[4:0], i_cmd_valid[1] & ~i_cmd_write};
		wr0_q <= {wr0_q[4:0], i_cmd_valid[0] & i_cmd_write};
		wr1_q <= {wr1_q[4:0], i_cmd_valid[1] & i_cmd_write};
		if (i_cmd_valid[0]) a0_q <= i_addr0;
		if (i_cmd_valid[1]) a1_q <= i_addr1;
	end
	assign o_ack = {wr1_q[1], wr0_q[1]};
	assign o_ret_valid = {rd1_q[4], rd0_q[2]};
	assign o_ret_ue = o_ret_valid & i_bad;
	// Outside a return the data lines show the inverse, so stale data never matches.
	assign o_data0 = rd0_q[2] ? {8{a0_q[31:0]}} : ~{8{a0_q[31:0]}};
	assign o_data1 = rd1_q[4] ? {8{a1_q[31:0]}} : ~{8{a1_q[31:0]}};
endmodule : dimm_chain_model

// >>> test/mirrored_memory_branch_control_tb.sv
// Self-checking bench for the mirrored memory branch controller.
`timescale 1ns/10ps
module mirrored_memory_branch_control_tb;
	logic i_clk = 0, i_rst_b = 0, i_link_clk = 0, i_cfg_load = 0, i_cfg_mirror = 0;
	logic i_cfg_single = 0, i_sw_degrade = 0, i_sw_degrade_br = 0, i_sw_resume = 0;
	logic i_stat_clr = 0, i_req_valid = 0, i_req_write = 0;
	logic [2:0] i_speed_b0 = 3'h0, i_speed_b1 = 3'h0, o_run_speed;
	logic [1:0] i_dimm_fail = 2'h0, bad = 2'h0, i_br_ack, i_ret_valid, i_ret_ue;
	logic [35:0] i_req_addr = 36'h0, i_req_addr_b = 36'h0, o_br_addr0, o_br_addr1;
	logic [127:0] i_req_wdata = 128'h0;
	logic [27:0] lanes = 28'h0;
	logic [255:0] i_ret_data0, i_ret_data1, o_resp_data, o_nb_payload0, o_nb_payload1;
	logic [1:0] o_online, o_br_cmd_valid, o_nb_valid, cmd, ce = 2'h0, sbit = 2'h0;
	logic [19:0] o_sb_lanes0, o_sb_lanes1;
	mirror_branch_pkg::mode_t o_mode;
	logic o_ecc_single, o_req_ready, o_req_refused, o_br_cmd_write, o_wr_done, o_resp_valid;
	logic o_resp_branch, o_resp_err, o_flag_offline, o_flag_ue_retry, done, refd;
	logic [255:0] rdat [2];
	logic rbr [2];
	logic rerr [2];
	int rcyc [2];
	int bad_count = 0, check_count = 0, nresp = 0;
	// Free-running reference clock, offset by 13 ns so its edges never fall on an i_clk edge.
	initial begin
		#13;
		forever #400 i_link_clk = ~i_link_clk;
	end
	initial begin
		forever #50 i_clk = ~i_clk;
	end
	mirrored_memory_branch_control DUT (.i_clk, .i_rst_b, .i_link_clk, .i_cfg_load, .i_cfg_mirror,
		.i_cfg_single, .i_speed_b0, .i_speed_b1, .i_sw_degrade, .i_sw_degrade_br, .i_sw_resume,
		.i_dimm_fail, .i_stat_clr, .i_req_valid, .i_req_write, .i_req_addr, .i_req_addr_b,
		.i_req_wdata, .i_br_ack, .i_ret_valid, .i_ret_data0, .i_ret_data1,
		.i_ret_ce(i_ret_valid & ce), .i_ret_ue, .i_ret_single_bit(i_ret_valid & sbit),
		.i_ret_dev0(5'h00), .i_ret_dev1(5'h00),
		.i_ret_adj16(1'b0), .i_nb_lanes0(lanes), .i_nb_lanes1(lanes), .o_mode, .o_ecc_single,
		.o_run_speed, .o_online, .o_req_ready, .o_req_refused, .o_br_cmd_valid, .o_br_cmd_write,
		.o_br_addr0, .o_br_addr1, .o_wr_done, .o_resp_valid, .o_resp_data, .o_resp_branch,
		.o_resp_err, .o_flag_offline, .o_flag_ue_retry, .o_sb_lanes0, .o_sb_lanes1,
		.o_nb_payload0, .o_nb_payload1, .o_nb_valid);
	dimm_chain_model far (.i_clk, .i_cmd_valid(o_br_cmd_valid), .i_cmd_write(o_br_cmd_write),
		.i_addr0(o_br_addr0), .i_addr1(o_br_addr1), .i_bad(bad), .o_ack(i_br_ack),
		.o_ret_valid(i_ret_valid), .o_ret_ue(i_ret_ue), .o_data0(i_ret_data0),
		.o_data1(i_ret_data1));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic timeout(input string nm);
		bad_count++;
		$display("MISMATCH %s expected completion seen timeout", nm);
		tally_and_finish();
	endtask : timeout
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge i_clk);
		s = 0;
		@(negedge i_clk);
	endtask : pulse
	// Reset for 20 cycles, then configure once with the given mode inputs.
	task automatic boot(input logic m, input logic s, input logic [2:0] a, input logic [2:0] b);
		@(negedge i_clk);
		i_rst_b = 0;
		repeat (20) @(negedge i_clk);
		i_rst_b = 1;
		chk("mode_reset", mirror_branch_pkg::MODE_UNSET, o_mode);
		chk("ready_reset", 0, o_req_ready);
		{i_cfg_mirror, i_cfg_single, i_speed_b0, i_speed_b1} = {m, s, a, b};
		pulse(i_cfg_load);
	endtask : boot
	// One request; records commands, completions and responses until ready returns.
	task automatic req(input logic w, input logic [35:0] a, input logic [35:0] b);
		int n;
		// One idle edge keeps the request strobe from being reassigned in a single step.
		@(negedge i_clk);
		for (n = 0; o_req_ready !== 1'b1; n++) begin
			if (n > 50) timeout("ready");
			@(negedge i_clk);
		end
		{cmd, done, refd} = 4'h0;
		nresp = 0;
		rerr = '{1'b0, 1'b0};
		i_req_write = w;
		i_req_addr = a;
		i_req_addr_b = b;
		i_req_wdata = {4{a[31:0]}};
		i_req_valid = 1;
		@(negedge i_clk);
		i_req_valid = 0;
		// Commands and refusals stand one cycle, so the first look is at this edge.
		for (n = 0; n < 60; n++) begin
			if (cmd === 2'h0) cmd = o_br_cmd_valid;
			done = done | o_wr_done;
			refd = refd | o_req_refused;
			if (o_resp_valid === 1'b1 && nresp < 2) begin
				rdat[nresp] = o_resp_data;
				rbr[nresp] = o_resp_branch;
				rerr[nresp] = o_resp_err;
				rcyc[nresp] = n;
				nresp++;
			end
			if (o_req_ready === 1'b1) break;
			@(negedge i_clk);
		end
		if (n == 60) timeout("request");
	endtask : req
	task automatic t_dual;
		boot(0, 0, 3'h5, 3'h2);
		chk("mode", mirror_branch_pkg::MODE_DUAL, o_mode);
		chk("online", 2'h3, o_online);
		chk("ecc_dual", 0, o_ecc_single);
		i_cfg_mirror = 1;
		pulse(i_cfg_load);
		chk("mode_kept", mirror_branch_pkg::MODE_DUAL, o_mode);
		req(1, 36'h000000040, 36'h0);
		chk("wr_cmd", 2'h2, cmd);
		chk("wr_done", 1, done);
		req(0, 36'h000000100, 36'h0);
		chk("rd_cmd", 2'h1, cmd);
		chk("rd_data", {8{32'h00000100}}, rdat[0]);
		$display("test dual done");
	endtask : t_dual
	// Lanes 13 and 27 only are high; payload must stay empty, frames every 12 rises.
	task automatic t_frame;
		int n;
		int f;
		f = 0;
		lanes = 28'h8002000;
		repeat (24) @(negedge i_clk);
		for (n = 0; n < 288; n++) begin
			@(negedge i_clk);
			if (o_nb_valid[0] === 1'b1) begin
				f++;
				chk("nb_payload", 0, o_nb_payload0);
				chk("nb_payload1", 0, o_nb_payload1);
				chk("nb_both", 2'h3, o_nb_valid);
			end
		end
		chk("frames", 3, f);
		$display("test frame done");
	endtask : t_frame
	task automatic t_single;
		boot(0, 1, 3'h4, 3'h4);
		chk("mode", mirror_branch_pkg::MODE_SINGLE, o_mode);
		chk("ecc_single", 1, o_ecc_single);
		req(1, 36'h000000040, 36'h0);
		chk("single_cmd", 2'h1, cmd);
		$display("test single done");
	endtask : t_single
	task automatic t_mirror;
		int n;
		boot(1, 0, 3'h3, 3'h6);
		chk("mode", mirror_branch_pkg::MODE_MIRROR, o_mode);
		chk("ecc_single", 0, o_ecc_single);
		chk("speed", 3, o_run_speed);
		req(1, 36'h000001240, 36'h0);
		chk("wr_cmd", 2'h3, cmd);
		chk("wr_done", 1, done);
		// The next southbound frame head carries valid, write and the top address bits.
		for (n = 0; n < 120 && o_sb_lanes0[19:18] !== 2'h3; n++) begin
			@(negedge i_clk);
		end
		chk("sb_head", {2{20'hc0000}}, {o_sb_lanes1, o_sb_lanes0});
		req(0, 36'h000001240, 36'h000005680);
		chk("rd_cmd", 2'h3, cmd);
		chk("rd_data0", {8{32'h00001240}}, rdat[0]);
		chk("rd_data1", {8{32'h00005680}}, rdat[1]);
		chk("rd_branch", 2'h2, {rbr[1], rbr[0]});
		chk("stagger", 2, rcyc[1] - rcyc[0]);
		req(0, 36'h800000040, 36'h0);
		chk("refused", 1, refd);
		chk("ref_cmd", 0, cmd);
		chk("ref_err", 1, rerr[0]);
		$display("test mirror done");
	endtask : t_mirror
	task automatic t_retry;
		bad = 2'h1;
		req(0, 36'h000002300, 36'h000004500);
		bad = 2'h0;
		chk("ue_flag", 1, o_flag_ue_retry);
		chk("retry_branch", 1, rbr[1]);
		chk("retry_data", {8{32'h00002300}}, rdat[1]);
		chk("retry_err", 0, rerr[1]);
		pulse(i_stat_clr);
		chk("flag_clear", 0, o_flag_ue_retry);
		// Three corrected returns on device 0 mark it; a single-bit error then retries.
		ce = 2'h1;
		repeat (3) req(0, 36'h000002300, 36'h000004500);
		chk("ce_err", 0, rerr[0]);
		chk("ce_data", {8{32'h00002300}}, rdat[0]);
		{ce, sbit} = 4'h1;
		req(0, 36'h000002300, 36'h000004500);
		sbit = 2'h0;
		chk("mark_retry", 1, o_flag_ue_retry);
		chk("mark_data", {8{32'h00002300}}, rdat[1]);
		$display("test retry done");
	endtask : t_retry
	task automatic t_degrade;
		i_sw_degrade_br = 1;
		pulse(i_sw_degrade);
		chk("online_deg", 2'h1, o_online);
		chk("offline_flag", 1, o_flag_offline);
		bad = 2'h1;
		req(0, 36'h000003100, 36'h000006100);
		bad = 2'h0;
		chk("deg_cmd", 2'h1, cmd);
		chk("deg_err", 1, rerr[nresp-1]);
		pulse(i_sw_resume);
		chk("online_res", 2'h3, o_online);
		i_dimm_fail = 2'h1;
		@(negedge i_clk);
		i_dimm_fail = 2'h0;
		@(negedge i_clk);
		chk("online_fail", 2'h2, o_online);
		req(0, 36'h000003100, 36'h000006100);
		chk("fail_cmd", 2'h2, cmd);
		$display("test degrade done");
	endtask : t_degrade
	initial begin
		t_dual();
		t_frame();
		t_single();
		t_mirror();
		t_retry();
		t_degrade();
		tally_and_finish();
	end
endmodule : mirrored_memory_branch_control_tb
